//--- rtl/fsp_core.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Operation
// - programming time counted in rc oscillator ticks, not system clocks
// - erase, write or lock-bit write lasts 3.7 ms to 4.5 ms
// - a reset during programming lets the operation finish
// - pages of 64 words, 128 bytes; erase and write act on whole page
// - two-bit boot fuse picks 4, 8, 16 or 32 pages at flash top
// - top 32 pages form no-rww area; 0x3000 or 0x1000 start
// - program counter is 13 bits wide
// - page select taken from pointer bits 13 to 7
// - word select taken from pointer bits 6 to 1
// - pointer bit 0 zero for commands; byte select on program reads
// - command runs only if store follows control write within four cycles
// - rww busy flag blocks rww reads until re-enable command or reset
module fsp_core
  import fsp_pkg::*;
#(
  parameter bit          BIG_VARIANT = 1'b1,
  parameter int unsigned PROG_TICKS  = PROG_TICKS_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rc_tick,
  input  wire logic [1:0]  boot_size_fuse,
  input  wire logic [15:0] read_addr,
  output logic             read_blocked,
  output logic             read_byte_hi,
  output logic             read_in_boot,
  output logic             flash_erase,
  output logic             flash_write,
  output logic             flash_lock,
  output logic [6:0]       flash_page,
  output logic             irq
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  initial begin
    if (PROG_TICKS < PROG_TICKS_MIN || PROG_TICKS > PROG_TICKS_MAX) begin
      $error("programming tick count outside allowed window");
    end
  end

  // ------------------------------------------------------------
  // address map helpers
  // ------------------------------------------------------------
  // split a byte pointer into page, word and byte select
  function automatic fsp_addr_s split_ptr(input logic [15:0] z);
    fsp_addr_s a;
    a.page    = z[POINTER_COUNTER_TOP_BIT:POINTER_PAGE_WORD_TOP_BIT+1];
    a.word    = z[POINTER_PAGE_WORD_TOP_BIT:1];
    a.byte_hi = z[0];
    return a;
  endfunction

  // true when byte address falls in the no-rww area
  function automatic logic in_no_read_while_write_area(input logic [15:0] z);
    logic [15:0] lim;
    lim = BIG_VARIANT ? NO_READ_WHILE_WRITE_AREA_START_16K : NO_READ_WHILE_WRITE_AREA_START_8K;
    return (z >= lim);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fsp_state_e        state_q, state_d;
  fsp_op_e           op_q, op_d;
  logic [15:0]       ptr_q, ptr_d;
  logic [4:0]        ctrl_q, ctrl_d;
  logic [2:0]        arm_cnt_q, arm_cnt_d;
  logic [12:0]       tick_cnt_q, tick_cnt_d;
  logic              rww_busy_q, rww_busy_d;
  logic [6:0]        page_q, page_d;
  logic [EV_WIDTH-1:0] ev_q, ev_d;
  logic [EV_WIDTH-1:0] msk_q, msk_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              err_q, err_d;
  logic              acc_q, acc_d;
  logic              run_q;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic pre_acc;
  logic wr_acc;
  logic rd_acc;
  logic store;
  logic [EV_WIDTH-1:0] ev_set;
  fsp_addr_s zf;

  // first access cycle prepares read data, second one completes the transfer
  assign pre_acc = psel && penable && !acc_q;
  assign acc_d   = pre_acc;
  assign wr_acc  = psel && penable && pwrite && acc_q;
  assign rd_acc  = psel && penable && !pwrite && acc_q;
  assign store   = wr_acc && (paddr == OFS_STORE);
  assign zf      = split_ptr(ptr_q);

  // one wait state: read data and error already registered when ready
  assign pready  = psel && penable && acc_q;
  assign prdata  = rdata_q;
  assign pslverr = err_q;

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    op_d       = op_q;
    ctrl_d     = ctrl_q;
    arm_cnt_d  = arm_cnt_q;
    tick_cnt_d = tick_cnt_q;
    rww_busy_d = rww_busy_q;
    page_d     = page_q;
    ptr_d      = ptr_q;
    ev_set     = '0;
    if (wr_acc && paddr == OFS_POINTER && state_q != ST_PROG) begin
      ptr_d = pwdata[15:0];
    end
    case (state_q)
      ST_IDLE: begin
        if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_ENABLE_BIT]) begin
          ctrl_d    = pwdata[4:0];
          arm_cnt_d = 3'(ARM_WINDOW_CYCLES);
          state_d   = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (store) begin
          state_d = ST_IDLE;
          ctrl_d  = '0;
          if (zf.byte_hi || (ctrl_q[CTRL_WRITE_BIT] && zf.word != '0)) begin
            ev_set[EV_REJECT_BIT] = 1'b1;
          end else if (ctrl_q[CTRL_REENABLE_BIT]) begin
            rww_busy_d = 1'b0;
          end else if (ctrl_q[CTRL_ERASE_BIT] || ctrl_q[CTRL_WRITE_BIT]
                       || ctrl_q[CTRL_LOCK_BIT]) begin
            op_d = ctrl_q[CTRL_ERASE_BIT] ? OP_ERASE :
                   ctrl_q[CTRL_WRITE_BIT] ? OP_WRITE : OP_LOCK;
            page_d     = zf.page;
            tick_cnt_d = 13'(PROG_TICKS);
            state_d    = ST_PROG;
            if (!ctrl_q[CTRL_LOCK_BIT] && !in_no_read_while_write_area(ptr_q)) begin
              rww_busy_d = 1'b1;
            end
          end
        end else if (arm_cnt_q == 3'h1) begin
          state_d               = ST_IDLE;
          ctrl_d                = '0;
          ev_set[EV_LAPSE_BIT]  = 1'b1;
        end else begin
          arm_cnt_d = arm_cnt_q - 3'h1;
        end
      end
      ST_PROG: begin
        if (rc_tick) begin
          if (tick_cnt_q == 13'h1) begin
            state_d              = ST_IDLE;
            op_d                 = OP_NONE;
            ev_set[EV_DONE_BIT]  = 1'b1;
          end else begin
            tick_cnt_d = tick_cnt_q - 13'h1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // interrupt flags and read data
  // ------------------------------------------------------------
  always_comb begin
    ev_d    = ev_q | ev_set;
    msk_d   = msk_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    if (!(psel && penable)) begin
      err_d = 1'b0;
    end
    if (wr_acc && paddr == OFS_IRQ_MSK) begin
      msk_d = pwdata[EV_WIDTH-1:0];
    end
    // clear only what was shown, events arriving meanwhile survive
    if (rd_acc && paddr == OFS_IRQ_ST) begin
      ev_d = (ev_q & ~rdata_q[EV_WIDTH-1:0]) | ev_set;
    end
    if (pre_acc) begin
      err_d = 1'b0;
    end
    if (pre_acc && !pwrite) begin
      if (paddr == OFS_CTRL) begin
        rdata_d = {27'h0, ctrl_q};
      end else if (paddr == OFS_POINTER) begin
        rdata_d = {16'h0, ptr_q};
      end else if (paddr == OFS_STATUS) begin
        rdata_d = {24'h0, state_q == ST_ARMED, rww_busy_q, 3'h0, op_q,
                   state_q == ST_PROG};
      end else if (paddr == OFS_IRQ_ST) begin
        rdata_d = {29'h0, ev_q};
      end else if (paddr == OFS_IRQ_MSK) begin
        rdata_d = {29'h0, msk_q};
      end else if (paddr == OFS_MAP) begin
        rdata_d = {16'h0, 3'h0, page_q, 6'h0};
      end else begin
        rdata_d = 32'h0;
        err_d   = 1'b1;
      end
    end else if (pre_acc && !(paddr == OFS_CTRL || paddr == OFS_POINTER
                 || paddr == OFS_IRQ_MSK || paddr == OFS_STORE)) begin
      err_d = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registers kept through reset: an operation in flight finishes
  // ------------------------------------------------------------
  // unknown state at power-up falls to the reset branch
  always_ff @(posedge pclk) begin
    if (presetn || state_q == ST_PROG) begin
      state_q  <= state_d;
      op_q     <= op_d;
    end else begin
      state_q  <= ST_IDLE;
      op_q     <= OP_NONE;
    end
    tick_cnt_q <= tick_cnt_d;
    page_q     <= page_d;
    run_q      <= (state_d == ST_PROG);
  end

  // ------------------------------------------------------------
  // ordinary control registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= '0;
      arm_cnt_q  <= '0;
      ptr_q      <= '0;
      ev_q       <= '0;
      msk_q      <= '0;
      rdata_q    <= '0;
      err_q      <= 1'b0;
      acc_q      <= 1'b0;
      rww_busy_q <= 1'b0;
    end else begin
      acc_q      <= acc_d;
      ctrl_q     <= ctrl_d;
      arm_cnt_q  <= arm_cnt_d;
      ptr_q      <= ptr_d;
      ev_q       <= ev_d;
      msk_q      <= msk_d;
      rdata_q    <= rdata_d;
      err_q      <= err_d;
      rww_busy_q <= rww_busy_d;
    end
  end

  // ------------------------------------------------------------
  // flash side and read path
  // ------------------------------------------------------------
  // boot section: 2^(2+inverted fuse) pages at the top
  logic [2:0]  boot_log;
  logic [7:0]  boot_pages;
  logic [16:0] boot_start;
  logic [16:0] flash_bytes;

  assign boot_log    = BOOT_PAGES_LOG_MIN + {1'b0, ~boot_size_fuse};
  assign boot_pages  = 8'(1) << boot_log;
  assign flash_bytes = BIG_VARIANT ? 17'h4000 : 17'h2000;
  assign boot_start  = flash_bytes - 17'({boot_pages, 7'h0});

  assign read_in_boot = {1'b0, read_addr} >= boot_start;
  assign read_blocked = rww_busy_q && !in_no_read_while_write_area(read_addr);
  assign read_byte_hi = read_addr[0];
  assign flash_erase  = run_q && (op_q == OP_ERASE);
  assign flash_write  = run_q && (op_q == OP_WRITE);
  assign flash_lock   = run_q && (op_q == OP_LOCK);
  assign flash_page   = page_q;
  assign irq          = |(ev_q & msk_q);

endmodule

//--- rtl/fsp_pkg.sv
package fsp_pkg;

  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_POINTER = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFS_MAP     = 8'h14;
  localparam logic [7:0] OFS_STORE   = 8'h18;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_ERASE_BIT    = 1;
  localparam int CTRL_WRITE_BIT    = 2;
  localparam int CTRL_LOCK_BIT     = 3;
  localparam int CTRL_REENABLE_BIT = 4;

  // status fields
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_RWW_BUSY_BIT = 6;
  localparam int ST_ARMED_BIT    = 7;

  // event bits of interrupt status and mask
  localparam int EV_DONE_BIT   = 0;
  localparam int EV_LAPSE_BIT  = 1;
  localparam int EV_REJECT_BIT = 2;
  localparam int EV_WIDTH      = 3;

  // ------------------------------------------------------------
  // flash geometry
  // ------------------------------------------------------------
  localparam int PAGE_WORDS                = 64;
  localparam int PAGE_BYTES                = 128;
  localparam int PROGRAM_COUNTER_TOP_BIT   = 12;
  localparam int PAGE_WORD_TOP_BIT         = 5;
  localparam int POINTER_COUNTER_TOP_BIT   = 13;
  localparam int POINTER_PAGE_WORD_TOP_BIT = 6;
  localparam int NO_READ_WHILE_WRITE_AREA_PAGES                = 32;
  localparam logic [15:0] NO_READ_WHILE_WRITE_AREA_START_16K   = 16'h3000;
  localparam logic [15:0] NO_READ_WHILE_WRITE_AREA_START_8K    = 16'h1000;
  localparam logic [2:0]  BOOT_PAGES_LOG_MIN = 3'h2; // 4 pages at fuse code 11

  // ------------------------------------------------------------
  // timing: lock-window, programming time from the rc timebase
  // ------------------------------------------------------------
  localparam int ARM_WINDOW_CYCLES = 4;
  localparam int PROG_MIN_US       = 3700;
  localparam int PROG_MAX_US       = 4500;
  localparam int RC_TICK_KHZ       = 1000; // rc timebase tick rate
  localparam int PROG_TICKS_MIN    = (PROG_MIN_US * RC_TICK_KHZ + 999) / 1000;
  localparam int PROG_TICKS_MAX    = (PROG_MAX_US * RC_TICK_KHZ) / 1000;
  localparam int PROG_TICKS_DEF    = (PROG_TICKS_MIN + PROG_TICKS_MAX) / 2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_LOCK  = 2'b11
  } fsp_op_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG  = 2'b10
  } fsp_state_e;

  typedef struct packed {
    logic [6:0] page;
    logic [5:0] word;
    logic       byte_hi;
  } fsp_addr_s;

endpackage

//--- verification/fsp_core_monitor.sv
`timescale 1ns/1ps
module fsp_core_monitor
  import fsp_pkg::*;
#(
  parameter bit          BIG_VARIANT = 1'b1,
  parameter int unsigned PROG_TICKS  = PROG_TICKS_DEF
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        pready,
  input wire logic        rc_tick,
  input wire logic [1:0]  boot_size_fuse,
  input wire logic [15:0] read_addr,
  input wire logic        read_blocked,
  input wire logic        read_byte_hi,
  input wire logic        read_in_boot,
  input wire logic        flash_erase,
  input wire logic        flash_write,
  input wire logic        flash_lock,
  input wire logic [6:0]  flash_page
);
  logic        op;
  logic        acc;
  logic [15:0] top_w;
  logic [15:0] bst_w;
  logic [15:0] tk_q, tk_d;
  logic [15:0] ptr_q, ptr_d;

  // operation flag, flash top and boot section start
  assign op    = flash_erase | flash_write | flash_lock;
  assign acc   = psel & penable;
  assign top_w = BIG_VARIANT ? 16'h4000 : 16'h2000;
  assign bst_w = top_w - (16'h0200 << (2'h3 - boot_size_fuse));

  // tick count of the running operation, last pointer written
  always_comb begin
    tk_d  = op ? tk_q + {15'h0, rc_tick} : 16'h0;
    ptr_d = ptr_q;
    if (acc && pwrite && paddr == OFS_POINTER && !op) ptr_d = pwdata[15:0];
  end

  // no reset: an operation runs on through reset
  always_ff @(posedge pclk) begin
    tk_q <= tk_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ptr_q <= 16'h0;
    else ptr_q <= ptr_d;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prog_ticks: assert property (
    $fell(op) |-> tk_q >= PROG_TICKS - 1 && tk_q <= PROG_TICKS + 1) else $error("bad op length");
  a_prog_max: assert property (
    op |-> tk_q <= PROG_TICKS_MAX) else $error("op too long");
  a_tick_paced: assert property (
    op && !rc_tick |=> op) else $error("op ended without tick");
  a_store_start: assert property (
    $rose(op) |-> $past(acc && pwrite && paddr == OFS_STORE)) else $error("op without store");
  a_page_sel: assert property (
    $rose(flash_erase | flash_write) |-> flash_page == ptr_q[13:7]) else $error("bad page");
  a_page_whole: assert property (
    op && $past(op) |-> $stable(flash_page)) else $error("page moved");
  a_reject_ptr: assert property (
    $rose(op) |-> ptr_q[0] == 1'b0 && !(flash_write && ptr_q[6:1] != 6'h0))
    else $error("bad pointer accepted");
  a_byte_sel: assert property (
    read_byte_hi == read_addr[0]) else $error("bad byte select");
  a_rww_block: assert property (
    read_blocked |-> read_addr < (BIG_VARIANT ? NO_READ_WHILE_WRITE_AREA_START_16K : NO_READ_WHILE_WRITE_AREA_START_8K))
    else $error("no-rww read blocked");
  a_boot_area: assert property (
    read_addr < top_w |-> read_in_boot == (read_addr >= bst_w)) else $error("bad boot area");
  a_unmapped_err: assert property (
    acc && !pready && paddr > OFS_STORE |=> pslverr) else $error("no slave error");

  c_erase: cover property ($rose(flash_erase));
  c_write: cover property ($rose(flash_write));
  c_lock: cover property ($rose(flash_lock));
  c_err: cover property ($rose(pslverr));
endmodule

bind fsp_core fsp_core_monitor #(.BIG_VARIANT(BIG_VARIANT), .PROG_TICKS(PROG_TICKS)) u_mon (.*);

//--- verification/fsp_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module fsp_core_tb;
  import fsp_pkg::*;
  typedef struct packed {logic [1:0] f; logic [15:0] s;} fsp_row_s;
  fsp_row_s    rows [4] = '{'{2'h3, 16'h3E00}, '{2'h2, 16'h3C00},
                            '{2'h1, 16'h3800}, '{2'h0, 16'h3000}};
  logic        pclk = 1'b0, presetn = 1'b0, rc_tick = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic        blk, bhi, inb, fe, fw, fl;
  logic [1:0]  fuse = 2'h3;
  logic [7:0]  paddr;
  logic [15:0] raddr = 16'h0;
  logic [31:0] pwdata, prdata, d;
  logic [6:0]  fpage;
  logic        e;
  int          err_total = 0, checks = 0;

  always #2.5 pclk = ~pclk;
  // rc tick every second clock
  always @(posedge pclk) rc_tick <= ~rc_tick;

  fsp_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_tick(rc_tick), .boot_size_fuse(fuse), .read_addr(raddr),
    .read_blocked(blk), .read_byte_hi(bhi), .read_in_boot(inb), .flash_erase(fe),
    .flash_write(fw), .flash_lock(fl), .flash_page(fpage), .irq(irq));
  fsp_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // start one operation, time it, optionally reset midway
  task automatic run_op(input logic [4:0] c, input logic [15:0] p, input logic [6:0] pg,
                        input bit rst);
    int n;
    n = 0;
    u_cpu.wr(OFS_POINTER, {16'h0, p});
    u_cpu.cmd({27'h0, c});
    #1 `CHK({fl, fw, fe}, c[3:1])
    if (!c[3]) `CHK(fpage, pg)
    if (rst) begin
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1 `CHK(fw, 1'b1)
      @(posedge pclk) presetn <= 1'b1;
      n = 4;
    end
    while ((fe | fw | fl) && n < 20000) begin
      @(posedge pclk);
      #1 n++;
    end
    `CHK(n >= 2 * PROG_TICKS_MIN - 4 && n <= 2 * PROG_TICKS_MAX + 4, 1'b1)
    if (!rst) begin
      @(posedge pclk);
      #1 `CHK(irq, 1'b1)
      u_cpu.rd(OFS_IRQ_ST, d, e);
      `CHK(d, 32'h1)
      `CHK(irq, 1'b0)
    end
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    u_cpu.rd(OFS_STATUS, d, e);
    `CHK(d, 32'h0)
    `CHK(e, 1'b0)
    // boot section edges per fuse code
    foreach (rows[i]) begin
      @(posedge pclk) fuse <= rows[i].f;
      raddr <= rows[i].s;
      @(posedge pclk) #1 `CHK({inb, bhi}, 2'b10)
      @(posedge pclk) raddr <= rows[i].s - 16'h1;
      @(posedge pclk) #1 `CHK({inb, bhi}, 2'b01)
    end
    u_cpu.rd(8'h40, d, e);
    `CHK(e, 1'b1)
    u_cpu.wr(OFS_IRQ_MSK, 32'h1);
    // store never follows: request lapses
    u_cpu.wr(OFS_CTRL, 32'h5);
    repeat (8) @(posedge pclk);
    #1 `CHK({fw, irq}, 2'b00)
    u_cpu.rd(OFS_IRQ_ST, d, e);
    `CHK(d, 32'h2)
    // odd pointer, then write with word select set
    for (int i = 0; i < 2; i++) begin
      u_cpu.wr(OFS_POINTER, i ? 32'h2 : 32'h1);
      u_cpu.cmd(i ? 32'h5 : 32'h3);
      #1 `CHK({fw, fe}, 2'b00)
      u_cpu.rd(OFS_IRQ_ST, d, e);
      `CHK(d, 32'h4)
    end
    @(posedge pclk) raddr <= 16'h0;
    run_op(5'h03, 16'h0280, 7'h05, 1'b0);
    `CHK(blk, 1'b1)
    run_op(5'h05, 16'h3000, 7'h60, 1'b0);
    run_op(5'h09, 16'h0000, 7'h00, 1'b0);
    u_cpu.rd(OFS_STATUS, d, e);
    `CHK(d[ST_RWW_BUSY_BIT], 1'b1)
    u_cpu.cmd(32'h11);
    repeat (4) @(posedge pclk);
    u_cpu.rd(OFS_STATUS, d, e);
    `CHK({d[ST_RWW_BUSY_BIT], blk}, 2'b00)
    run_op(5'h05, 16'h1F80, 7'h3F, 1'b1);
    end_of_test();
  end

  // watchdog
  initial begin
    #300000;
    err_total++;
    end_of_test();
  end
endmodule

//--- verification/fsp_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// cpu side: apb master running boot loader accesses
// ------------------------------------------------------------
module fsp_cpu_model
  import fsp_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // setup, then access held until pready seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r       = prdata; // taken at the ready edge
    e       = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  // data and error taken with ready, then let effects settle
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
    xfer(1'b0, a, 32'h0, d, e);
    #1;
  endtask

  // control write, store follows at once
  task automatic cmd(input logic [31:0] c);
    wr(OFS_CTRL, c);
    wr(OFS_STORE, 32'h0);
  endtask
endmodule
